// file: hdl/ipr_top.sv
// Interrupt pin routing: two pin drivers, event routing, AXI4-Lite registers
// Functional notes
// R1: Pin asserted level is low when polarity bit is 0, high when 1.
// R2: Drive-type bit 0 gives push-pull, 1 gives open-drain.
// R3: Pin is driven only while its output-enable bit is 1.
// R4: Pin is sampled as input only while its input-enable bit is 1.
// R5: Hold bit 0 gives non-latched pins; 1 latches asserted pins.
// R6: Pin A feature map routes seven feature events at bits 0 to 6.
// R7: Pin B has its own feature map, same bits, bit 7 reserved.
// R8: Step bit routes one source: step watermark or step detector.
// R9: Queue-full goes to A by data bit 0, to B by bit 4.
// R10: Queue-level goes to A by data bit 1, to B by bit 5.
// R11: Fresh-sample goes to A by data bit 2, to B by bit 6.
// R12: Fault goes to A by data bit 3, to B by bit 7.
// R13: Fault event is formed only from error flags enabled in the mask.
// R14: Pin condition is OR of its routed events, driven per settings.
// R15: Disabled output, and open-drain inactive level, are released; code releases only the open-drain high level, so polarity 1 drives low.
//
// The AXI4-Lite slave port is this design's own decision.
`default_nettype none
module ipr_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [ipr_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ipr_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Event sources, one-clock logic
    input wire logic sig_motion,
    input wire logic step_watermark,
    input wire logic step_detect,
    input wire logic activity,
    input wire logic wrist_wear,
    input wire logic wrist_gesture,
    input wire logic no_motion,
    input wire logic any_motion,
    input wire logic queue_full,
    input wire logic queue_level,
    input wire logic sample_fresh,
    input wire logic [7:0] error_flags,
    // Interrupt pins, enables low while driving
    output logic irq_pin_a_o,
    output logic irq_pin_a_oe_n,
    input wire logic irq_pin_a_i,
    output logic irq_pin_b_o,
    output logic irq_pin_b_oe_n,
    input wire logic irq_pin_b_i,
    // Summary interrupt
    output logic irq
);
    // Pin condition from routed events
    function automatic logic route_cond(input ipr_pkg::ipr_feat_t f, input logic [7:0] fmap,
                                        input ipr_pkg::ipr_data_t d, input logic [3:0] dmap);
        route_cond = (|(f[6:0] & fmap[6:0])) | (|(d & dmap)); // R6 R7 R14
    endfunction

    // Electrical drive of one pin: {level, enable_n}
    function automatic logic [1:0] pin_drive(input logic cond, input ipr_pkg::ipr_elec_t e);
        logic lvl;
        lvl = cond ? e.polarity : ~e.polarity; // R1
        pin_drive = {lvl, ~(e.output_en & (~e.drain_select | ~lvl))}; // R2 R3 R15
    endfunction

    ipr_pkg::ipr_elec_t elec_a_reg, elec_b_reg;
    logic [7:0] hold_reg, feat_a_reg, feat_b_reg, err_mask_reg, ctrl_reg;
    ipr_pkg::ipr_dmap_t dmap_reg;
    logic [10:0] status_reg, irq_mask_reg;
    logic latch_a_reg, latch_b_reg, cond_a_reg, cond_b_reg;
    logic sync_a1_reg, sync_a2_reg, sync_b1_reg, sync_b2_reg, samp_a_reg, samp_b_reg;
    logic [ipr_pkg::ADDR_W-1:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_write;
    logic [7:0] widx;
    logic clr_a, clr_b;
    ipr_pkg::ipr_feat_t feat;
    ipr_pkg::ipr_data_t dev;
    logic [10:0] evt;
    logic raw_a, raw_b, cond_a, cond_b;
    logic [31:0] rd_word;
    logic rd_ok;

    // Write happens once both address and data are held and no response is pending
    assign do_write = ~awready & ~wready & ~bvalid;
    assign widx = waddr_reg[9:2];

    // Address and data channels are taken independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= ipr_pkg::RESP_OKAY;
            waddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                waddr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp <= word_ok(waddr_reg) ? ipr_pkg::RESP_OKAY : ipr_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Decode of a mapped, word-aligned address
    function automatic logic word_ok(input logic [ipr_pkg::ADDR_W-1:0] a);
        logic [7:0] i;
        i = a[9:2];
        word_ok = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
                  ((i >= ipr_pkg::IDX_ERR_MASK && i <= ipr_pkg::IDX_DATA_ROUTE) ||
                   (i >= ipr_pkg::IDX_STATUS && i <= ipr_pkg::IDX_CTRL));
    endfunction

    // Configuration registers; only byte lane 0 carries them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            elec_a_reg <= ipr_pkg::REG_RESET;
            elec_b_reg <= ipr_pkg::REG_RESET;
            hold_reg <= ipr_pkg::REG_RESET;
            feat_a_reg <= ipr_pkg::REG_RESET;
            feat_b_reg <= ipr_pkg::REG_RESET;
            dmap_reg <= ipr_pkg::REG_RESET;
            err_mask_reg <= ipr_pkg::REG_RESET;
            ctrl_reg <= ipr_pkg::REG_RESET;
        end else if (do_write && wstrb_reg[0] && word_ok(waddr_reg)) begin
            unique case (widx)
                ipr_pkg::IDX_ELEC_A: elec_a_reg <= wdata_reg[7:0];
                ipr_pkg::IDX_ELEC_B: elec_b_reg <= wdata_reg[7:0];
                ipr_pkg::IDX_HOLD: hold_reg <= wdata_reg[7:0];
                ipr_pkg::IDX_FEAT_A: feat_a_reg <= wdata_reg[7:0];
                ipr_pkg::IDX_FEAT_B: feat_b_reg <= wdata_reg[7:0];
                ipr_pkg::IDX_DATA_ROUTE: dmap_reg <= wdata_reg[7:0];
                ipr_pkg::IDX_ERR_MASK: err_mask_reg <= wdata_reg[7:0];
                ipr_pkg::IDX_CTRL: ctrl_reg <= {7'h00, wdata_reg[ipr_pkg::CTRL_STEP_SRC]};
                default: ;
            endcase
        end
    end

    // Latch-clear pulses are write-only and never stored
    assign clr_a = do_write && wstrb_reg[0] && widx == ipr_pkg::IDX_CTRL &&
                   word_ok(waddr_reg) && wdata_reg[ipr_pkg::CTRL_CLR_A];
    assign clr_b = do_write && wstrb_reg[0] && widx == ipr_pkg::IDX_CTRL &&
                   word_ok(waddr_reg) && wdata_reg[ipr_pkg::CTRL_CLR_B];

    // Event vectors; step takes one source only
    always_comb begin
        feat = '0;
        feat.sig_motion = sig_motion; // R6
        feat.step = ctrl_reg[ipr_pkg::CTRL_STEP_SRC] ? step_detect : step_watermark; // R8
        feat.activity = activity;
        feat.wrist_wear = wrist_wear;
        feat.wrist_gesture = wrist_gesture;
        feat.no_motion = no_motion;
        feat.any_motion = any_motion;
        dev.queue_full = queue_full;
        dev.queue_level = queue_level;
        dev.sample_fresh = sample_fresh;
        dev.fault = |(error_flags & err_mask_reg); // R13
        evt = {dev.fault, dev.sample_fresh, dev.queue_level, dev.queue_full, feat[6:0]};
    end

    // Routing to each pin; reserved feature bit 7 is ignored
    assign raw_a = route_cond(feat, feat_a_reg, dev, dmap_reg[3:0]); // R9 R10 R11 R12
    assign raw_b = route_cond(feat, feat_b_reg, dev, dmap_reg[7:4]); // R9 R10 R11 R12
    assign cond_a = hold_reg[ipr_pkg::HOLD_BIT] ? (raw_a | latch_a_reg) : raw_a; // R5
    assign cond_b = hold_reg[ipr_pkg::HOLD_BIT] ? (raw_b | latch_b_reg) : raw_b; // R5

    // Latched mode holds until software clears; a new event beats the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_a_reg <= 1'b0;
            latch_b_reg <= 1'b0;
        end else begin
            latch_a_reg <= hold_reg[ipr_pkg::HOLD_BIT] & ((latch_a_reg & ~clr_a) | raw_a); // R5
            latch_b_reg <= hold_reg[ipr_pkg::HOLD_BIT] & ((latch_b_reg & ~clr_b) | raw_b); // R5
        end
    end

    // Pin drivers come straight from flops; released while in reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {irq_pin_a_o, irq_pin_a_oe_n} <= 2'h1;
            {irq_pin_b_o, irq_pin_b_oe_n} <= 2'h1;
            cond_a_reg <= 1'b0;
            cond_b_reg <= 1'b0;
        end else begin
            {irq_pin_a_o, irq_pin_a_oe_n} <= pin_drive(cond_a, elec_a_reg); // R1 R2 R3 R14
            {irq_pin_b_o, irq_pin_b_oe_n} <= pin_drive(cond_b, elec_b_reg); // R1 R2 R3 R14
            cond_a_reg <= cond_a;
            cond_b_reg <= cond_b;
        end
    end

    // Pin inputs are asynchronous; two flops before the enable gate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {sync_a1_reg, sync_a2_reg, sync_b1_reg, sync_b2_reg} <= 4'h0;
            samp_a_reg <= 1'b0;
            samp_b_reg <= 1'b0;
        end else begin
            sync_a1_reg <= irq_pin_a_i;
            sync_a2_reg <= sync_a1_reg;
            sync_b1_reg <= irq_pin_b_i;
            sync_b2_reg <= sync_b1_reg;
            samp_a_reg <= elec_a_reg.input_en & sync_a2_reg; // R4
            samp_b_reg <= elec_b_reg.input_en & sync_b2_reg; // R4
        end
    end

    // Sticky status with write-one-to-clear; a set in the clear cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= ipr_pkg::EVT_RESET;
            irq_mask_reg <= ipr_pkg::EVT_RESET;
            irq <= 1'b0;
        end else begin
            if (do_write && widx == ipr_pkg::IDX_STATUS && word_ok(waddr_reg))
                status_reg <= (status_reg & ~(wdata_reg[10:0] & {{3{wstrb_reg[1]}},
                              {8{wstrb_reg[0]}}})) | evt;
            else
                status_reg <= status_reg | evt;
            if (do_write && widx == ipr_pkg::IDX_IRQ_MASK && word_ok(waddr_reg)) begin
                if (wstrb_reg[0]) irq_mask_reg[7:0] <= wdata_reg[7:0];
                if (wstrb_reg[1]) irq_mask_reg[10:8] <= wdata_reg[10:8];
            end
            irq <= |(status_reg & irq_mask_reg);
        end
    end

    // Read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = word_ok(araddr);
        unique case (araddr[9:2])
            ipr_pkg::IDX_ELEC_A: rd_word[7:0] = elec_a_reg;
            ipr_pkg::IDX_ELEC_B: rd_word[7:0] = elec_b_reg;
            ipr_pkg::IDX_HOLD: rd_word[7:0] = hold_reg;
            ipr_pkg::IDX_FEAT_A: rd_word[7:0] = feat_a_reg;
            ipr_pkg::IDX_FEAT_B: rd_word[7:0] = feat_b_reg;
            ipr_pkg::IDX_DATA_ROUTE: rd_word[7:0] = dmap_reg;
            ipr_pkg::IDX_ERR_MASK: rd_word[7:0] = err_mask_reg;
            ipr_pkg::IDX_STATUS: rd_word[10:0] = status_reg;
            ipr_pkg::IDX_IRQ_MASK: rd_word[10:0] = irq_mask_reg;
            ipr_pkg::IDX_PIN_STATE: rd_word[3:0] = {samp_b_reg, samp_a_reg, cond_b_reg, cond_a_reg};
            ipr_pkg::IDX_CTRL: rd_word[7:0] = ctrl_reg;
            default: rd_word = 32'h0000_0000;
        endcase
        if (!rd_ok) rd_word = 32'h0000_0000;
    end

    // Read channel answers one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= ipr_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_ok ? ipr_pkg::RESP_OKAY : ipr_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence quiet_a_s;
        !raw_a && !latch_a_reg;
    endsequence
    sequence held_a_s;
        hold_reg[0] && cond_a && !clr_a;
    endsequence

    pol_low_a: assert property (cond_a && !elec_a_reg.polarity |=> !irq_pin_a_o) // R1
        else $error("pin a not low when asserted active low");
    pol_high_b_a: assert property (cond_b && elec_b_reg.polarity |=> irq_pin_b_o) // R1
        else $error("pin b not high when asserted active high");
    push_pull_a: assert property (elec_a_reg.output_en && !elec_a_reg.drain_select
        |=> !irq_pin_a_oe_n) // R2
        else $error("push-pull pin a not driven");
    drain_release_a: assert property (!$past(elec_a_reg.output_en) || irq_pin_a_o &&
        $past(elec_a_reg.drain_select) |-> irq_pin_a_oe_n) // R3 R15
        else $error("pin a driven while it must be released");
    input_gate_a: assert property (!elec_a_reg.input_en [*2] |-> !samp_a_reg) // R4
        else $error("pin a sampled while input disabled");
    latch_keep_a: assert property (held_a_s ##1 hold_reg[0] && !clr_a |-> cond_a) // R5
        else $error("latched pin a dropped without clear");
    nonlatch_a: assert property (!hold_reg[0] ##0 quiet_a_s |=> !cond_a_reg) // R5 R14
        else $error("pin a asserted with no event");
    fifo_route_a: assert property (queue_full && dmap_reg.queue_full_to_a |-> raw_a) // R9
        else $error("queue full not routed to pin a");
    fault_mask_a: assert property ((error_flags & err_mask_reg) == 8'h00 && // R13
        dmap_reg[3:0] == 4'h8 && feat_a_reg[6:0] == 7'h00 |-> !raw_a)
        else $error("masked error flag reached pin a");
    step_src_a: assert property (feat_b_reg[1] && ctrl_reg[0] && step_detect |-> raw_b) // R8
        else $error("step detector not routed to pin b");
    sticky_a: assert property (evt[0] |=> status_reg[0])
        else $error("event lost from status");
    irq_level_a: assert property (|(status_reg & irq_mask_reg) |=> irq)
        else $error("unmasked status did not raise irq");
endmodule
`default_nettype wire

// file: hdl/ipr_pkg.sv
// Constants and carrier types for the interrupt pin routing block
`default_nettype none
package ipr_pkg;
    // Register indices; the byte address of each is four times its index
    localparam logic [7:0] IDX_ERR_MASK = 8'h52;
    localparam logic [7:0] IDX_ELEC_A = 8'h53;
    localparam logic [7:0] IDX_ELEC_B = 8'h54;
    localparam logic [7:0] IDX_HOLD = 8'h55;
    localparam logic [7:0] IDX_FEAT_A = 8'h56;
    localparam logic [7:0] IDX_FEAT_B = 8'h57;
    localparam logic [7:0] IDX_DATA_ROUTE = 8'h58;
    localparam logic [7:0] IDX_STATUS = 8'h60;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h61;
    localparam logic [7:0] IDX_PIN_STATE = 8'h62;
    localparam logic [7:0] IDX_CTRL = 8'h63;
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Values after reset
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [10:0] EVT_RESET = 11'h000;
    // Field positions
    localparam int HOLD_BIT = 0;
    localparam int CTRL_STEP_SRC = 0;
    localparam int CTRL_CLR_A = 1;
    localparam int CTRL_CLR_B = 2;
    localparam int ST_COND_A = 0;
    localparam int ST_COND_B = 1;
    localparam int ST_IN_A = 2;
    localparam int ST_IN_B = 3;
    localparam int EVT_W = 11;
    localparam int EVT_FFULL = 7;
    localparam int EVT_ERR = 10;

    // Electrical settings of one pin
    typedef struct packed {
        logic [2:0] spare_hi;
        logic input_en;
        logic output_en;
        logic drain_select;
        logic polarity;
        logic spare_lo;
    } ipr_elec_t;

    // Feature events, bit 0 first from the right
    typedef struct packed {
        logic reserved;
        logic any_motion;
        logic no_motion;
        logic wrist_gesture;
        logic wrist_wear;
        logic activity;
        logic step;
        logic sig_motion;
    } ipr_feat_t;

    // Data events
    typedef struct packed {
        logic fault;
        logic sample_fresh;
        logic queue_level;
        logic queue_full;
    } ipr_data_t;

    // Data event routing to both pins
    typedef struct packed {
        logic fault_to_b;
        logic sample_fresh_to_b;
        logic queue_level_to_b;
        logic queue_full_to_b;
        logic fault_to_a;
        logic sample_fresh_to_a;
        logic queue_level_to_a;
        logic queue_full_to_a;
    } ipr_dmap_t;
endpackage
`default_nettype wire

// file: tb/ipr_host_model.sv
// Host side of the two interrupt pins: pull-ups, wired level and host pull-down
`default_nettype none
module ipr_host_model (
    // Pin A
    input wire logic pin_a_o,
    input wire logic pin_a_oe_n,
    input wire logic pull_a_low,
    output logic wire_a,
    // Pin B
    input wire logic pin_b_o,
    input wire logic pin_b_oe_n,
    input wire logic pull_b_low,
    output logic wire_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // Board pull-up holds a released line high; the host can only pull it low,
    // so the wired level is the AND of every driver
    assign wire_a = (pin_a_oe_n ? 1'b1 : pin_a_o) & ~pull_a_low;
    assign wire_b = (pin_b_oe_n ? 1'b1 : pin_b_o) & ~pull_b_low;
endmodule
`default_nettype wire

// file: tb/irq_pin_routing_bench.sv
// Self-checking bench for the interrupt pin routing block
`default_nettype none
module irq_pin_routing_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [1:0] kind; logic [33:0] val;} ipr_note_t;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq, pin_chk;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [18:0] ev;
    logic pa_o, pa_oe_n, pb_o, pb_oe_n, wire_a, wire_b, low_a, low_b;
    ipr_note_t note_q[$];
    int n_fail;
    int checked;

    // Design and host side joined through the wired pin levels
    ipr_top i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .sig_motion(ev[0]), .step_watermark(ev[1]), .step_detect(ev[2]),
        .activity(ev[3]), .wrist_wear(ev[4]), .wrist_gesture(ev[5]), .no_motion(ev[6]),
        .any_motion(ev[7]), .queue_full(ev[8]), .queue_level(ev[9]), .sample_fresh(ev[10]),
        .error_flags(ev[18:11]), .irq_pin_a_o(pa_o), .irq_pin_a_oe_n(pa_oe_n),
        .irq_pin_a_i(wire_a), .irq_pin_b_o(pb_o), .irq_pin_b_oe_n(pb_oe_n),
        .irq_pin_b_i(wire_b), .irq);
    ipr_host_model i_host (.pin_a_o(pa_o), .pin_a_oe_n(pa_oe_n), .pull_a_low(low_a),
        .wire_a, .pin_b_o(pb_o), .pin_b_oe_n(pb_oe_n), .pull_b_low(low_b), .wire_b);

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic timeout(input string what);
        n_fail++;
        $display("BAD %s expected handshake seen none", what);
        give_verdict();
    endtask

    // Oldest note against what the outputs show now
    task automatic take(input logic [1:0] k, input logic [33:0] got);
        ipr_note_t nt;
        checked++;
        if (note_q.size() == 0) begin
            n_fail++;
            $display("BAD queue expected note seen none");
        end else begin
            nt = note_q.pop_front();
            if (nt.kind !== k || nt.val !== got) begin
                n_fail++;
                $display("BAD %s expected %h seen %h", k == 0 ? "bresp" : k == 1 ? "read" : "pins",
                    nt.val, got);
            end
        end
    endtask

    // Watcher: values seen here are those before the edge, i.e. what the edge samples
    always @(posedge aclk) begin
        if (bvalid === 1'b1 && bready) take(2'd0, {32'h0, bresp});
        if (rvalid === 1'b1 && rready) take(2'd1, {rresp, rdata});
        if (pin_chk) take(2'd2, {29'h0, irq, pa_oe_n, wire_a, pb_oe_n, wire_b});
    end

    task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic aw, w, done;
        note_q.push_back('{2'd0, {32'h0, er}});
        @(posedge aclk);
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        done = 1'b0;
        for (n = 0; n < 200 && !done; n++) begin
            @(posedge aclk);
            done = !aw && !w && bvalid === 1'b1;
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b0;
        if (!done) timeout("write");
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ar, done;
        note_q.push_back('{2'd1, {er, d}});
        @(posedge aclk);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        ar = 1'b1;
        done = 1'b0;
        for (n = 0; n < 200 && !done; n++) begin
            @(posedge aclk);
            done = !ar && rvalid === 1'b1;
            if (ar && arready === 1'b1) begin
                ar = 1'b0;
                arvalid <= 1'b0;
            end
        end
        rready <= 1'b0;
        if (!done) timeout("read");
    endtask

    task automatic set_ev(input logic [18:0] v);
        @(posedge aclk);
        ev <= v;
    endtask

    // Pins need one edge to follow their inputs, so compare one edge later
    task automatic snap(input logic [4:0] e);
        @(posedge aclk);
        note_q.push_back('{2'd2, {29'h0, e}});
        pin_chk <= 1'b1;
        @(posedge aclk);
        pin_chk <= 1'b0;
    endtask

    // Expected {oe_n, wire}: c holds output enable, drain select, polarity
    function automatic logic [1:0] pin_exp(input logic [2:0] c, input logic cond);
        logic lvl, drv;
        lvl = cond ? c[0] : !c[0];
        drv = c[2] && (!c[1] || !lvl);
        return {!drv, drv ? lvl : 1'b1};
    endfunction

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Main sequence
    initial begin
        int i;
        logic [31:0] d;
        logic [2:0] c;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, pin_chk, low_a, low_b} = '0;
        {awaddr, araddr, wdata, ev} = '0;
        wstrb = 4'hf;
        n_fail = 0;
        checked = 0;
        void'($urandom(95));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 11; i++) rd(i < 7 ? 8'(8'h52 + i) : 8'(8'h59 + i), 32'h0, 2'h0);
        rd(8'h70, 32'h0, ipr_pkg::RESP_SLVERR);
        wr(8'h70, 32'hff, ipr_pkg::RESP_SLVERR);
        snap(5'b01111);
        $display("test reset done");
        for (i = 0; i < 7; i++) begin
            d = $urandom();
            wr(8'(8'h52 + i), d, 2'h0);
            rd(8'(8'h52 + i), {24'h0, d[7:0]}, 2'h0);
            wr(8'(8'h52 + i), 32'h0, 2'h0);
        end
        // Byte lane 0 off: the configuration byte must stay untouched
        wstrb <= 4'he;
        wr(ipr_pkg::IDX_HOLD, 32'hff, 2'h0);
        wstrb <= 4'hf;
        rd(ipr_pkg::IDX_HOLD, 32'h0, 2'h0);
        $display("test registers done");
        wr(ipr_pkg::IDX_FEAT_A, 32'h1, 2'h0);
        wr(ipr_pkg::IDX_DATA_ROUTE, 32'h10, 2'h0);
        for (i = 0; i < 16; i++) begin
            c = 3'(i >> 1);
            wr(ipr_pkg::IDX_ELEC_A, {28'h0, c, 1'b0}, 2'h0);
            wr(ipr_pkg::IDX_ELEC_B, {28'h0, c, 1'b0}, 2'h0);
            set_ev({10'h0, i[0], 7'h0, i[0]});
            snap({1'b0, pin_exp(c, i[0]), pin_exp(c, i[0])});
        end
        $display("test electrical done");
        wr(ipr_pkg::IDX_ELEC_A, 32'h0a, 2'h0);
        wr(ipr_pkg::IDX_ELEC_B, 32'h0a, 2'h0);
        wr(ipr_pkg::IDX_DATA_ROUTE, 32'h0, 2'h0);
        for (i = 0; i < 7; i++) begin
            wr(ipr_pkg::IDX_FEAT_A, 32'h1 << i, 2'h0);
            wr(ipr_pkg::IDX_FEAT_B, 32'h7f ^ (32'h1 << i), 2'h0);
            set_ev(19'h1 << (i < 2 ? i : i + 1));
            snap(5'b00100);
        end
        wr(ipr_pkg::IDX_FEAT_A, 32'h2, 2'h0);
        set_ev(19'h4);
        snap(5'b00000);
        wr(ipr_pkg::IDX_CTRL, 32'h1, 2'h0);
        snap(5'b00101);
        set_ev(19'h2);
        snap(5'b00000);
        wr(ipr_pkg::IDX_CTRL, 32'h0, 2'h0);
        wr(ipr_pkg::IDX_FEAT_A, 32'h80, 2'h0);
        wr(ipr_pkg::IDX_FEAT_B, 32'h80, 2'h0);
        set_ev(19'hff);
        snap(5'b00000);
        $display("test feature routing done");
        wr(ipr_pkg::IDX_FEAT_A, 32'h0, 2'h0);
        wr(ipr_pkg::IDX_FEAT_B, 32'h0, 2'h0);
        wr(ipr_pkg::IDX_ERR_MASK, 32'h1, 2'h0);
        for (i = 0; i < 8; i++) begin
            wr(ipr_pkg::IDX_DATA_ROUTE, 32'h1 << i, 2'h0);
            set_ev(i % 4 == 3 ? 19'h800 : 19'h100 << (i % 4));
            snap({2'b00, i < 4, 1'b0, i >= 4});
        end
        wr(ipr_pkg::IDX_DATA_ROUTE, 32'h88, 2'h0);
        set_ev({8'hfe, 11'h0});
        snap(5'b00000);
        wr(ipr_pkg::IDX_ERR_MASK, 32'hff, 2'h0);
        snap(5'b00101);
        $display("test data routing done");
        wr(ipr_pkg::IDX_DATA_ROUTE, 32'h0, 2'h0);
        wr(ipr_pkg::IDX_FEAT_A, 32'h1, 2'h0);
        wr(ipr_pkg::IDX_HOLD, 32'h1, 2'h0);
        set_ev(19'h1);
        set_ev(19'h0);
        snap(5'b00100);
        wr(ipr_pkg::IDX_CTRL, 32'h2, 2'h0);
        snap(5'b00000);
        wr(ipr_pkg::IDX_HOLD, 32'h0, 2'h0);
        set_ev(19'h1);
        set_ev(19'h0);
        snap(5'b00000);
        $display("test hold mode done");
        // Outputs off, inputs on: the host alone sets the pin level
        wr(ipr_pkg::IDX_ELEC_A, 32'h10, 2'h0);
        wr(ipr_pkg::IDX_ELEC_B, 32'h10, 2'h0);
        low_a <= 1'b1;
        low_b <= 1'b1;
        snap(5'b01010);
        repeat (4) @(posedge aclk);
        rd(ipr_pkg::IDX_PIN_STATE, 32'h0, 2'h0);
        low_a <= 1'b0;
        low_b <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(ipr_pkg::IDX_PIN_STATE, 32'h0c, 2'h0);
        wr(ipr_pkg::IDX_ELEC_A, 32'h0, 2'h0);
        wr(ipr_pkg::IDX_ELEC_B, 32'h0, 2'h0);
        repeat (4) @(posedge aclk);
        rd(ipr_pkg::IDX_PIN_STATE, 32'h0, 2'h0);
        $display("test input enable done");
        wr(ipr_pkg::IDX_STATUS, 32'h7ff, 2'h0);
        rd(ipr_pkg::IDX_STATUS, 32'h0, 2'h0);
        set_ev(19'h100);
        set_ev(19'h0);
        rd(ipr_pkg::IDX_STATUS, 32'h80, 2'h0);
        wr(ipr_pkg::IDX_IRQ_MASK, 32'h1, 2'h0);
        snap(5'b01111);
        wr(ipr_pkg::IDX_IRQ_MASK, 32'h80, 2'h0);
        snap(5'b11111);
        wr(ipr_pkg::IDX_STATUS, 32'h80, 2'h0);
        snap(5'b01111);
        rd(ipr_pkg::IDX_STATUS, 32'h0, 2'h0);
        $display("test interrupt done");
        give_verdict();
    end
endmodule
`default_nettype wire
